// >>> hw/tiex_defs.vh
`ifndef TIEX_DEFS_VH
`define TIEX_DEFS_VH
// Table area in program memory and entry count.
`define TIEX_TBL_LO        14'h0020
`define TIEX_TBL_HI        14'h007F
`define TIEX_TBL_ENTRIES   7'h30
// Reach of branch targets taken through the table.
`define TIEX_REACH_HI      14'h3FFF
// Entry usage kinds.
`define TIEX_USE_CALL      2'h0
`define TIEX_USE_BRANCH    2'h1
`define TIEX_USE_EXEC      2'h2
// String-effect groups.
`define TIEX_GRP_NONE      2'h0
`define TIEX_GRP_A         2'h1
`define TIEX_GRP_B         2'h2
// Bit addressing modes.
`define TIEX_BIT_FMEM      2'h0
`define TIEX_BIT_PMEM      2'h1
`define TIEX_BIT_PTR       2'h2
// Bit space bases.
`define TIEX_FMEM_FLAG_BASE 12'hFB0
`define TIEX_FMEM_PORT_BASE 12'hFF0
`define TIEX_PMEM_BASE     12'hFC0
// Bit operations.
`define TIEX_OP_TEST       3'h0
`define TIEX_OP_MOVE       3'h1
`define TIEX_OP_AND        3'h2
`define TIEX_OP_OR         3'h3
`define TIEX_OP_XOR        3'h4
`define TIEX_OP_SET        3'h5
`define TIEX_OP_CLR        3'h6
`endif

// >>> hw/tiex_core.v
`include "tiex_defs.vh"

module tiex_core (
	// Clock and reset
	input  wire        clk_sys_in,
	input  wire        sys_rst_in,
	// Decoded instruction stream, one step per machine cycle
	input  wire        insn_valid_in,
	input  wire        insn_is_table_in,
	input  wire [6:0]  insn_table_addr_in,
	input  wire [1:0]  insn_group_in,
	input  wire        skip_pending_in,
	input  wire [13:0] pc_in,
	// Table entry returned by program memory
	input  wire        entry_valid_in,
	input  wire [1:0]  entry_use_in,
	input  wire [13:0] entry_target_in,
	input  wire [1:0]  entry_group_in,
	input  wire        entry_skip_cond_in,
	// Bit operation request
	input  wire        bit_req_in,
	input  wire [2:0]  bit_op_in,
	input  wire [1:0]  bit_mode_in,
	input  wire [7:0]  bit_mem_in,
	input  wire [1:0]  bit_sel_in,
	input  wire [3:0]  reg_l_in,
	input  wire        bank_enable_flag_in,
	input  wire [3:0]  bank_select_reg_in,
	input  wire        bit_rd_data_in,
	input  wire        carry_in,
	// Table fetch toward program memory
	output reg         fetch_req_out,
	output reg  [13:0] fetch_addr_out,
	// Sequencing results
	output reg         pc_hold_out,
	output reg         pc_load_out,
	output reg  [13:0] pc_target_out,
	output reg         call_push_out,
	output reg  [13:0] call_return_out,
	output reg         exec_entry_out,
	output reg         skip_next_out,
	output reg         nop_out,
	output reg         table_fault_out,
	// Bit access toward data space
	output reg         bit_access_out,
	output reg  [3:0]  bit_bank_out,
	output reg  [11:0] bit_addr_out,
	output reg  [1:0]  bit_pos_out,
	output reg         bit_we_out,
	output reg         bit_wr_data_out,
	output reg         carry_out,
	output reg         carry_we_out
);

	localparam ST_IDLE  = 2'h0;
	localparam ST_FETCH = 2'h1;
	localparam ST_EXEC  = 2'h2;

	reg [1:0]  state;
	reg [1:0]  next_state;
	reg [1:0]  run_group;
	reg [1:0]  next_run_group;
	reg [13:0] ret_pc;
	reg [13:0] next_ret_pc;

	reg        n_fetch_req;
	reg [13:0] n_fetch_addr;
	reg        n_pc_hold;
	reg        n_pc_load;
	reg [13:0] n_pc_target;
	reg        n_call_push;
	reg        n_exec;
	reg        n_skip;
	reg        n_nop;
	reg        n_fault;

	wire [13:0] tbl_addr = {7'h00, insn_table_addr_in[6:1], 1'b0};
	wire        tbl_ok = (tbl_addr >= `TIEX_TBL_LO) &&
		(tbl_addr <= `TIEX_TBL_HI);
	wire        tgt_ok = (entry_target_in <= `TIEX_REACH_HI);

	always @* begin
		next_state     = state;
		next_run_group = run_group;
		next_ret_pc    = ret_pc;
		n_fetch_req    = 1'b0;
		n_fetch_addr   = fetch_addr_out;
		n_pc_hold      = 1'b0;
		n_pc_load      = 1'b0;
		n_pc_target    = pc_target_out;
		n_call_push    = 1'b0;
		n_exec         = 1'b0;
		n_skip         = 1'b0;
		n_nop          = 1'b0;
		n_fault        = 1'b0;
		case (state)
		ST_IDLE: begin
			if (insn_valid_in) begin
				if (skip_pending_in) begin
					// One cycle consumed, nothing fetched.
					next_run_group = `TIEX_GRP_NONE;
				end else if (insn_is_table_in) begin
					// An operand outside the table area never reaches memory.
					n_fetch_req  = tbl_ok;
					n_fetch_addr = tbl_addr;
					n_pc_hold    = 1'b1;
					next_ret_pc  = pc_in;
					n_fault      = ~tbl_ok;
					next_state   = tbl_ok ? ST_FETCH : ST_IDLE;
				end else if (insn_group_in != `TIEX_GRP_NONE &&
					insn_group_in == run_group) begin
					n_nop = 1'b1;
				end else begin
					next_run_group = insn_group_in;
				end
			end
		end
		ST_FETCH: begin
			n_pc_hold = 1'b1;
			if (entry_valid_in) begin
				case (entry_use_in)
				`TIEX_USE_CALL: begin
					n_pc_load   = 1'b1;
					n_call_push = 1'b1;
					n_pc_target = entry_target_in;
					n_fault     = ~tgt_ok;
					next_run_group = `TIEX_GRP_NONE;
					next_state  = ST_IDLE;
				end
				`TIEX_USE_BRANCH: begin
					n_pc_load   = 1'b1;
					n_pc_target = entry_target_in;
					n_fault     = ~tgt_ok;
					next_run_group = `TIEX_GRP_NONE;
					next_state  = ST_IDLE;
				end
				default: begin
					// Entry runs even if it matches the open run.
					n_exec         = 1'b1;
					next_run_group = entry_group_in;
					n_skip         = entry_skip_cond_in;
					next_state     = ST_EXEC;
				end
				endcase
			end
		end
		ST_EXEC: begin
			// Resume at the byte after the table opcode.
			n_pc_load   = 1'b1;
			n_pc_target = ret_pc;
			next_state  = ST_IDLE;
		end
		default: begin
			next_state = ST_IDLE;
		end
		endcase
	end

	always @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			state           <= ST_IDLE;
			run_group       <= `TIEX_GRP_NONE;
			ret_pc          <= 14'h0000;
			fetch_req_out   <= 1'b0;
			fetch_addr_out  <= 14'h0000;
			pc_hold_out     <= 1'b0;
			pc_load_out     <= 1'b0;
			pc_target_out   <= 14'h0000;
			call_push_out   <= 1'b0;
			call_return_out <= 14'h0000;
			exec_entry_out  <= 1'b0;
			skip_next_out   <= 1'b0;
			nop_out         <= 1'b0;
			table_fault_out <= 1'b0;
		end else begin
			state           <= next_state;
			run_group       <= next_run_group;
			ret_pc          <= next_ret_pc;
			fetch_req_out   <= n_fetch_req;
			fetch_addr_out  <= n_fetch_addr;
			pc_hold_out     <= n_pc_hold;
			pc_load_out     <= n_pc_load;
			pc_target_out   <= n_pc_target;
			call_push_out   <= n_call_push;
			call_return_out <= ret_pc;
			exec_entry_out  <= n_exec;
			skip_next_out   <= n_skip;
			nop_out         <= n_nop;
			table_fault_out <= n_fault;
		end
	end

	// Bit addressing.
	reg [11:0] n_addr;
	reg [1:0]  n_pos;
	reg [3:0]  n_bank;
	reg        n_we;
	reg        n_wd;
	reg        n_cy;
	reg        n_cywe;

	always @* begin
		n_addr = 12'h000;
		n_pos  = bit_sel_in;
		n_bank = 4'h0;
		n_we   = 1'b0;
		n_wd   = 1'b0;
		n_cy   = carry_in;
		n_cywe = 1'b0;
		case (bit_mode_in)
		`TIEX_BIT_FMEM: begin
			// Low half of the field picks flags, high half the ports.
			n_addr = bit_mem_in[4] ?
				(`TIEX_FMEM_PORT_BASE | {8'h00, bit_mem_in[3:0]}) :
				(`TIEX_FMEM_FLAG_BASE | {8'h00, bit_mem_in[3:0]});
			n_bank = 4'hF;
		end
		`TIEX_BIT_PMEM: begin
			n_addr = `TIEX_PMEM_BASE |
				{6'h00, bit_mem_in[5:2], reg_l_in[3:2]};
			n_pos  = reg_l_in[1:0];
			n_bank = 4'hF;
		end
		default: begin
			n_bank = {4{bank_enable_flag_in}} & bank_select_reg_in;
			n_addr = {4'h0, bit_mem_in};
		end
		endcase
		case (bit_op_in)
		`TIEX_OP_TEST: begin
			n_cy = bit_rd_data_in;
			n_cywe = 1'b1;
		end
		`TIEX_OP_MOVE: begin
			n_we = 1'b1;
			n_wd = carry_in;
		end
		`TIEX_OP_AND: begin
			n_cy = carry_in & bit_rd_data_in;
			n_cywe = 1'b1;
		end
		`TIEX_OP_OR: begin
			n_cy = carry_in | bit_rd_data_in;
			n_cywe = 1'b1;
		end
		`TIEX_OP_XOR: begin
			n_cy = carry_in ^ bit_rd_data_in;
			n_cywe = 1'b1;
		end
		`TIEX_OP_SET: begin
			n_we = 1'b1;
			n_wd = 1'b1;
		end
		`TIEX_OP_CLR: begin
			n_we = 1'b1;
			n_wd = 1'b0;
		end
		default: begin
			n_we = 1'b0;
		end
		endcase
	end

	always @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			bit_access_out  <= 1'b0;
			bit_bank_out    <= 4'h0;
			bit_addr_out    <= 12'h000;
			bit_pos_out     <= 2'h0;
			bit_we_out      <= 1'b0;
			bit_wr_data_out <= 1'b0;
			carry_out       <= 1'b0;
			carry_we_out    <= 1'b0;
		end else begin
			bit_access_out  <= bit_req_in;
			bit_bank_out    <= n_bank;
			bit_addr_out    <= n_addr;
			bit_pos_out     <= n_pos;
			bit_we_out      <= bit_req_in & n_we;
			bit_wr_data_out <= n_wd;
			carry_out       <= n_cy;
			carry_we_out    <= bit_req_in & n_cywe;
		end
	end

endmodule // tiex_core

// >>> test/tiex_core_properties.sv
module tiex_core_properties (
	input wire clk_sys_in, sys_rst_in, insn_valid_in, insn_is_table_in,
	input wire skip_pending_in, entry_valid_in, bit_req_in, pc_load_out,
	input wire bank_enable_flag_in, fetch_req_out, pc_hold_out,
	input wire call_push_out, exec_entry_out, nop_out, table_fault_out,
	input wire [1:0] insn_group_in, entry_use_in, bit_mode_in,
	input wire [3:0] bank_select_reg_in, bit_bank_out,
	input wire [6:0] insn_table_addr_in,
	input wire [7:0] bit_mem_in,
	input wire [11:0] bit_addr_out,
	input wire [13:0] entry_target_in, pc_target_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	reg busy, wt;
	reg [7:0] pm;
	wire take = (fetch_req_out | wt) & entry_valid_in;
	wire acc = insn_valid_in & ~busy & ~fetch_req_out;
	wire plain = acc & ~insn_is_table_in & ~skip_pending_in;
	wire tbl = acc & insn_is_table_in & ~skip_pending_in;
	wire low = insn_table_addr_in[6:5] == 2'h0;
	// Busy spans fetch to resume, as the core ignores requests meanwhile.
	always @(posedge clk_sys_in) begin
		busy <= ~sys_rst_in & (fetch_req_out | busy & ~pc_load_out);
		wt <= ~sys_rst_in & (fetch_req_out | wt) & ~entry_valid_in;
		pm <= bit_mem_in;
	end
	a_table_fetch: assert property (tbl && !low
		|=> fetch_req_out && pc_hold_out) else $error("no fetch");
	a_table_fault: assert property (tbl && low
		|=> table_fault_out && !fetch_req_out) else $error("no fault");
	a_skip_quiet: assert property (acc && insn_is_table_in
		&& skip_pending_in |=> !fetch_req_out && !pc_hold_out)
		else $error("skipped fetch");
	a_call_push: assert property (take && entry_use_in == 2'h0
		|=> call_push_out && pc_load_out && pc_target_out ==
		$past(entry_target_in)) else $error("bad call");
	a_exec_resume: assert property (take && entry_use_in[1]
		|=> exec_entry_out && pc_hold_out ##1 pc_load_out && !exec_entry_out)
		else $error("bad resume");
	a_group_nop: assert property (plain && insn_group_in != 2'h0 ##1 plain
		&& insn_group_in == $past(insn_group_in) |=> nop_out)
		else $error("run not dropped");
	a_bit_short: assert property (bit_req_in && bit_mode_in == 2'h0
		|=> bit_bank_out == 4'hF && bit_addr_out ==
		{pm[4] ? 8'hFF : 8'hFB, pm[3:0]}) else $error("bad short bit");
	a_bit_bank: assert property (bit_req_in && bit_mode_in[1]
		|=> bit_addr_out == {4'h0, pm} && bit_bank_out == ({4{$past(
		bank_enable_flag_in)}} & $past(bank_select_reg_in))) else $error("bad bank");
	cover property (take && entry_use_in == 2'h0);
	cover property (nop_out);
	cover property (exec_entry_out);
endmodule // tiex_core_properties

bind tiex_core tiex_core_properties tiex_core_properties_inst (.*);

// >>> test/tiex_pmem_model.sv
module tiex_pmem_model (
	input wire clk_sys_in, fetch_req_out,
	input wire [1:0] lat,
	input wire [13:0] fetch_addr_out,
	output logic entry_valid_in, entry_skip_cond_in,
	output logic [1:0] entry_use_in, entry_group_in,
	output logic [13:0] entry_target_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] age = 2'h0;
	wire [6:0] a = fetch_addr_out[6:0];
	wire v = fetch_req_out ? lat == 2'h0 : age != 2'h0 && age == lat;
	wire [18:0] e = {a[2:1], a[4:3] == 2'h3 ? 2'h0 : a[4:3], a[5],
		1'h0, a, 6'h15};
	always @(posedge clk_sys_in)
		age <= fetch_req_out | (age != 2'h0 && age < lat) ? age + 2'h1 : 2'h0;
	// Between answers the lines show the inverse, so stale data never passes.
	assign entry_valid_in = v;
	assign {entry_use_in, entry_group_in, entry_skip_cond_in,
		entry_target_in} = v ? e : ~e;
endmodule // tiex_pmem_model

// >>> test/table_indirect_exec_and_bit_addressing_test.sv
module table_indirect_exec_and_bit_addressing_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_in, sys_rst_in, insn_valid_in, insn_is_table_in, carry_in;
	logic skip_pending_in, entry_valid_in, entry_skip_cond_in, bit_req_in;
	logic bank_enable_flag_in, bit_rd_data_in, fetch_req_out, nop_out;
	logic pc_hold_out, pc_load_out, call_push_out, exec_entry_out;
	logic skip_next_out, table_fault_out, bit_access_out, carry_we_out;
	logic bit_we_out, bit_wr_data_out, carry_out;
	logic [1:0] insn_group_in, entry_use_in, entry_group_in, bit_mode_in;
	logic [1:0] bit_sel_in, bit_pos_out, lat;
	logic [2:0] bit_op_in;
	logic [3:0] reg_l_in, bank_select_reg_in, bit_bank_out;
	logic [6:0] insn_table_addr_in;
	logic [7:0] bit_mem_in;
	logic [11:0] bit_addr_out;
	logic [13:0] pc_in, entry_target_in, fetch_addr_out, pc_target_out;
	logic [13:0] call_return_out;
	logic [6:0] tab [5] = '{7'h20, 7'h22, 7'h24, 7'h44, 7'h7E};
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	tiex_core tiex_core_inst (.*);
	tiex_pmem_model tiex_pmem_model_inst (.*);
	initial begin
		clk_sys_in = 1'h0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end
	task report_and_stop;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			report_and_stop;
		end
	end
	task chk(input logic [13:0] s, e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task ins(input logic t, s, input logic [6:0] a, input logic [1:0] g);
		insn_valid_in <= 1'h1;
		insn_is_table_in <= t;
		skip_pending_in <= s;
		insn_table_addr_in <= a;
		insn_group_in <= g;
		@(posedge clk_sys_in);
	endtask
	task tbl(input logic [6:0] a, input logic [1:0] l);
		logic ex, sk;
		ex = 1'h0;
		sk = 1'h0;
		lat <= l;
		pc_in <= {7'h01, a};
		ins(1'h1, 1'h0, a, 2'h0);
		insn_valid_in <= 1'h0;
		#1 chk(fetch_req_out & pc_hold_out, 1'h1);
		chk(fetch_addr_out, {7'h00, a});
		repeat (8) if (!pc_load_out) begin
			@(posedge clk_sys_in);
			#1 ex |= exec_entry_out;
			sk |= skip_next_out;
		end
		chk(call_push_out, a[2:1] == 2'h0);
		if (a[2:1] == 2'h0) chk(call_return_out, {7'h01, a});
		chk(pc_target_out, a[2] ? {7'h01, a} : {1'h0, a, 6'h15});
		chk({pc_load_out, ex, sk}, {1'h1, a[2], a[2] & a[5]});
	endtask
	task skip_scn;
		@(posedge clk_sys_in);
		ins(1'h1, 1'h1, 7'h22, 2'h0);
		#1 chk(fetch_req_out | pc_hold_out, 1'h0);
		tbl(7'h22, 2'h0);
	endtask
	task string_scn;
		@(posedge clk_sys_in);
		ins(1'h0, 1'h0, 7'h00, 2'h1);
		tbl(7'h2C, 2'h1);
		@(posedge clk_sys_in);
		ins(1'h0, 1'h0, 7'h00, 2'h1);
		#1 chk(nop_out, 1'h1);
	endtask
	task group_scn;
		for (int g = 1; g < 3; g++) begin
			ins(1'h0, 1'h0, 7'h00, 2'h0);
			ins(1'h0, 1'h0, 7'h00, g[1:0]);
			#1 chk(nop_out, 1'h0);
			ins(1'h0, 1'h0, 7'h00, g[1:0]);
			#1 chk(nop_out, 1'h1);
			ins(1'h0, 1'h0, 7'h00, 2'h3 - g[1:0]);
			#1 chk(nop_out, 1'h0);
		end
	endtask
	task fault_scn;
		ins(1'h1, 1'h0, 7'h10, 2'h0);
		insn_valid_in <= 1'h0;
		#1 chk({table_fault_out, fetch_req_out}, 2'h2);
		sys_rst_in <= 1'h1;
		repeat (2) @(posedge clk_sys_in);
		sys_rst_in <= 1'h0;
		@(posedge clk_sys_in);
		tbl(7'h7E, 2'h1);
	endtask
	task bit_scn;
		for (int m = 0; m < 3; m++)
			for (int o = 0; o < 7; o++) begin
				bit_req_in <= 1'h1;
				bit_mode_in <= m[1:0];
				bit_op_in <= o[2:0];
				bit_mem_in <= {1'h0, o[2:0], 4'h5};
				{bank_enable_flag_in, carry_in, bit_rd_data_in} <=
					{o[0], o[0], o[1] | ~o[0]};
				@(posedge clk_sys_in);
				bit_req_in <= 1'h0;
				#1 chk(bit_addr_out, m == 0 ? {o[0] ? 8'hFF : 8'hFB, 4'h5} : m == 1
					? {6'h3F, o[1:0], 4'h6} : {5'h00, o[2:0], 4'h5});
				chk(bit_pos_out, m == 1 ? 2'h1 : 2'h2);
				if (m != 1)
					chk(bit_bank_out, m == 0 ? 4'hF : {4{o[0]}} & 4'hA);
				chk({bit_access_out, bit_we_out}, {1'h1, o == 1 || o > 4});
				if (o == 1 || o > 4) chk(bit_wr_data_out, o != 6);
				chk(carry_we_out, o == 0 || (o > 1 && o < 5));
				if (o != 1 && o < 5) chk(carry_out, o != 2);
			end
	endtask
	initial begin
		{insn_valid_in, insn_is_table_in, skip_pending_in, bit_req_in} = 4'h0;
		{insn_table_addr_in, insn_group_in, pc_in, lat} = 25'h0;
		{bit_op_in, bit_mode_in, bit_mem_in, bank_enable_flag_in} = 14'h0;
		{bit_rd_data_in, carry_in, bit_sel_in} = 4'h2;
		{reg_l_in, bank_select_reg_in} = 8'h9A;
		sys_rst_in = 1'h1;
		repeat (6) @(posedge clk_sys_in);
		sys_rst_in <= 1'h0;
		foreach (tab[i]) begin
			@(posedge clk_sys_in);
			tbl(tab[i], i[1:0]);
		end
		skip_scn;
		string_scn;
		group_scn;
		fault_scn;
		bit_scn;
		report_and_stop;
	end
endmodule // table_indirect_exec_and_bit_addressing_test
